/* File: src/vsv_pkg.sv */
// constants for the output-voltage setpoint and voltage-id select block
package vsv_pkg;
  localparam logic [7:0] VSV_ADDR_STORE_ALL = 8'h15;
  localparam logic [7:0] VSV_ADDR_SER_READBACK = 8'h31;
  localparam logic [7:0] VSV_ADDR_CTRL_SELECT = 8'hA0;
  localparam logic [7:0] VSV_ADDR_SETPOINT = 8'hA6;
  localparam logic [7:0] VSV_ADDR_ACTIVE_CODE = 8'hA7;
  localparam logic [7:0] VSV_ADDR_OFFSET = 8'hA8;
  localparam logic [7:0] VSV_ADDR_STEP_BOOT = 8'hC2;
  // step_and_boot_config layout: step select in [1:0], boot field in [7:4]
  localparam int VSV_STEP_LSB = 0;
  localparam int VSV_BOOT_LSB = 4;
  localparam logic [1:0] VSV_CTRL_SERIAL = 2'h0;
  localparam logic [1:0] VSV_CTRL_SHARED = 2'h1;
  localparam logic [7:0] VSV_RST_SETPOINT = 8'h00;
  localparam logic [7:0] VSV_RST_OFFSET = 8'h00;
  localparam logic [7:0] VSV_RST_STEP_BOOT = 8'h00;
  localparam logic [1:0] VSV_RST_CTRL = 2'h0;
  localparam logic [7:0] VSV_CODE_MAX = 8'hFF;
  // millivolt table: code 0 is 0 V, code n is base + n steps
  localparam logic [11:0] VSV_BASE_MV_5 = 12'h0F5;
  localparam logic [11:0] VSV_BASE_MV_10 = 12'h1EA;
  localparam logic [11:0] VSV_STEP_MV_5 = 12'h005;
  localparam logic [11:0] VSV_STEP_MV_10 = 12'h00A;
  localparam logic [3:0] VSV_BOOT_LAST_FINE = 4'hC;
endpackage

/* File: src/vsv_code_to_mv.sv */
// common code-to-millivolt table for every setpoint source
`timescale 1ns/10ps
module vsv_code_to_mv import vsv_pkg::*; (
  input wire logic [7:0] code,
  input wire logic step_fine,
  output logic [11:0] mv
);
  always_comb begin
    if (code == 8'h00) begin
      mv = 12'h000;
    end else if (step_fine) begin
      mv = VSV_BASE_MV_5 + VSV_STEP_MV_5 * {4'h0, code};
    end else begin
      mv = VSV_BASE_MV_10 + VSV_STEP_MV_10 * {4'h0, code};
    end
  end
endmodule

/* File: src/vsv_setpoint.sv */
// output setpoint registers, boot-code map and regulation target selection
//
// What this block does
// - i2c modes take start target from setpoint
// - fine step spans 0.25 to 1.52 V
// - coarse step spans 0.50 to 3.04 V
// - after start, i2c-mode setpoint/offset writes act the next cycle
// - store-all saves setpoint, power-on reloads it
// - boot 0 is 0 V; 1..12 fine only
// - boot 13..15 map 6F/79/83, coarse only
// - active code read-only, readable at two places
// - one code table for both interfaces
// - incompatible boot/step write gets nack
// - code 0 is 0 V, then base plus steps
// - control select picks governing interface
// - control select latched at enable rising
`timescale 1ns/10ps
module vsv_setpoint import vsv_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_ACK,
  output logic REG_NACK,
  input wire logic CONV_EN,
  input wire logic SS_DONE,
  input wire logic SER_CODE_VALID,
  input wire logic [7:0] SER_CODE,
  output logic [7:0] SER_READBACK,
  input wire logic NVM_LOAD,
  input wire logic [7:0] NVM_LOAD_SETPOINT,
  input wire logic [7:0] NVM_LOAD_STEP_BOOT,
  output logic NVM_SAVE,
  output logic [7:0] NVM_SAVE_SETPOINT,
  output logic [7:0] NVM_SAVE_STEP_BOOT,
  output logic [7:0] TARGET_CODE,
  output logic [11:0] TARGET_MV,
  output logic [1:0] CTRL_ACTIVE
);
  typedef struct packed {
    logic [7:0] setpoint_reg;
    logic [7:0] offset_reg;
    logic [7:0] offset_start_reg;
    logic [7:0] step_boot_reg;
    logic [1:0] ctrl_sel_reg;
    logic [1:0] ctrl_latched_reg;
    logic en_d_reg;
    logic [7:0] active_reg;
    logic [11:0] mv_reg;
    logic [7:0] rdata_reg;
    logic ack_reg;
    logic nack_reg;
    logic save_reg;
    logic [7:0] save_sp_reg;
    logic [7:0] save_sb_reg;
  } vsv_state_t;

  vsv_state_t st_reg;
  vsv_state_t st_next;
  logic [11:0] table_mv;

  // 4-bit boot field to voltage-id code
  function automatic logic [7:0] boot_to_code(input logic [3:0] boot);
    case (boot)
      4'h0: boot_to_code = 8'h00;
      4'h1: boot_to_code = 8'h65;
      4'h2: boot_to_code = 8'h6F;
      4'h3: boot_to_code = 8'h79;
      4'h4: boot_to_code = 8'h83;
      4'h5: boot_to_code = 8'h8D;
      4'h6: boot_to_code = 8'h97;
      4'h7: boot_to_code = 8'hA1;
      4'h8: boot_to_code = 8'hAB;
      4'h9: boot_to_code = 8'hAF;
      4'hA: boot_to_code = 8'hC9;
      4'hB: boot_to_code = 8'hDD;
      4'hC: boot_to_code = 8'hFB;
      4'hD: boot_to_code = 8'h6F;
      4'hE: boot_to_code = 8'h79;
      default: boot_to_code = 8'h83;
    endcase
  endfunction

  function automatic logic step_is_fine(input logic [1:0] step);
    step_is_fine = (step == 2'h1) || (step == 2'h2);
  endfunction

  // setpoint plus signed offset, clamped to 01..FF; zero stays zero
  function automatic logic [7:0] apply_offset(input logic [7:0] sp, input logic [7:0] ofs);
    logic [9:0] sum;
    sum = {2'b00, sp} + {{2{ofs[7]}}, ofs};
    if (sp == 8'h00) begin
      apply_offset = 8'h00;
    end else if (sum[9]) begin
      apply_offset = 8'h01;
    end else if (sum[8]) begin
      apply_offset = VSV_CODE_MAX;
    end else if (sum[7:0] == 8'h00) begin
      apply_offset = 8'h01;
    end else begin
      apply_offset = sum[7:0];
    end
  endfunction

  function automatic logic boot_step_ok(input logic [7:0] cfg);
    logic [3:0] boot;
    boot = cfg[VSV_BOOT_LSB +: 4];
    if (boot == 4'h0) begin
      boot_step_ok = 1'b1;
    end else if (boot <= VSV_BOOT_LAST_FINE) begin
      boot_step_ok = step_is_fine(cfg[VSV_STEP_LSB +: 2]);
    end else begin
      boot_step_ok = !step_is_fine(cfg[VSV_STEP_LSB +: 2]);
    end
  endfunction

  // every target code goes through the same converter
  vsv_code_to_mv u_conv (
    .code(st_next.active_reg),
    .step_fine(step_is_fine(st_next.step_boot_reg[VSV_STEP_LSB +: 2])),
    .mv(table_mv)
  );

  always_comb begin
    logic [1:0] mode;
    logic i2c_mode;
    logic run;
    logic en_rise;
    st_next = st_reg;
    st_next.ack_reg = 1'b0;
    st_next.nack_reg = 1'b0;
    st_next.save_reg = 1'b0;
    en_rise = CONV_EN && !st_reg.en_d_reg;
    // while disabled the written select governs, while enabled the latched copy does
    mode = st_reg.en_d_reg ? st_reg.ctrl_latched_reg : st_reg.ctrl_sel_reg;
    i2c_mode = mode[1];
    run = st_reg.en_d_reg && CONV_EN && SS_DONE;
    st_next.en_d_reg = CONV_EN;

    if (NVM_LOAD) begin
      st_next.setpoint_reg = NVM_LOAD_SETPOINT;
      st_next.step_boot_reg = NVM_LOAD_STEP_BOOT;
    end

    if (REG_WR) begin
      st_next.ack_reg = 1'b1;
      case (REG_ADDR)
        VSV_ADDR_STORE_ALL: begin
          st_next.save_reg = 1'b1;
          st_next.save_sp_reg = st_reg.setpoint_reg;
          st_next.save_sb_reg = st_reg.step_boot_reg;
        end
        VSV_ADDR_CTRL_SELECT: st_next.ctrl_sel_reg = REG_WDATA[1:0];
        VSV_ADDR_SETPOINT: begin
          // acknowledged in serial modes but has no effect there
          if (i2c_mode) begin
            st_next.setpoint_reg = REG_WDATA;
          end
        end
        VSV_ADDR_OFFSET: begin
          if (mode == VSV_CTRL_SERIAL) begin
            st_next.ack_reg = 1'b0;
            st_next.nack_reg = 1'b1;
          end else begin
            st_next.offset_reg = REG_WDATA;
          end
        end
        VSV_ADDR_STEP_BOOT: begin
          if (boot_step_ok(REG_WDATA)) begin
            st_next.step_boot_reg = REG_WDATA;
          end else begin
            st_next.ack_reg = 1'b0;
            st_next.nack_reg = 1'b1;
          end
        end
        default: begin
          // read-only and unmapped addresses refuse the write
          st_next.ack_reg = 1'b0;
          st_next.nack_reg = 1'b1;
        end
      endcase
    end else if (REG_RD) begin
      st_next.ack_reg = 1'b1;
      case (REG_ADDR)
        VSV_ADDR_SER_READBACK: st_next.rdata_reg = st_reg.active_reg;
        VSV_ADDR_ACTIVE_CODE: st_next.rdata_reg = st_reg.active_reg;
        VSV_ADDR_CTRL_SELECT: st_next.rdata_reg = {6'h00, st_reg.ctrl_sel_reg};
        VSV_ADDR_SETPOINT: st_next.rdata_reg = st_reg.setpoint_reg;
        VSV_ADDR_OFFSET: st_next.rdata_reg = st_reg.offset_reg;
        VSV_ADDR_STEP_BOOT: st_next.rdata_reg = st_reg.step_boot_reg;
        default: begin
          st_next.rdata_reg = 8'h00;
          st_next.ack_reg = 1'b0;
          st_next.nack_reg = 1'b1;
        end
      endcase
    end

    if (en_rise) begin
      st_next.ctrl_latched_reg = st_reg.ctrl_sel_reg;
      st_next.offset_start_reg = st_reg.offset_reg;
      if (st_reg.ctrl_sel_reg[1]) begin
        st_next.active_reg = apply_offset(st_reg.setpoint_reg, st_reg.offset_reg);
      end else if (st_reg.ctrl_sel_reg == VSV_CTRL_SHARED) begin
        st_next.active_reg = apply_offset(boot_to_code(st_reg.step_boot_reg[VSV_BOOT_LSB +: 4]),
                                          st_reg.offset_reg);
      end else begin
        st_next.active_reg = boot_to_code(st_reg.step_boot_reg[VSV_BOOT_LSB +: 4]);
      end
    end else if (!CONV_EN) begin
      st_next.active_reg = 8'h00;
    end else if (run && i2c_mode) begin
      // tracks the stored values, so a write lands the cycle after it is taken
      st_next.active_reg = apply_offset(st_reg.setpoint_reg, st_reg.offset_reg);
    end else if (run && SER_CODE_VALID) begin
      // shared mode keeps the offset captured at start-up
      st_next.active_reg = (mode == VSV_CTRL_SHARED) ?
                           apply_offset(SER_CODE, st_reg.offset_start_reg) : SER_CODE;
    end
    st_next.mv_reg = table_mv;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
      st_reg.setpoint_reg <= VSV_RST_SETPOINT;
      st_reg.offset_reg <= VSV_RST_OFFSET;
      st_reg.step_boot_reg <= VSV_RST_STEP_BOOT;
      st_reg.ctrl_sel_reg <= VSV_RST_CTRL;
      st_reg.ctrl_latched_reg <= VSV_RST_CTRL;
    end else begin
      st_reg <= st_next;
    end
  end

  assign REG_RDATA = st_reg.rdata_reg;
  assign REG_ACK = st_reg.ack_reg;
  assign REG_NACK = st_reg.nack_reg;
  assign SER_READBACK = st_reg.active_reg;
  assign NVM_SAVE = st_reg.save_reg;
  assign NVM_SAVE_SETPOINT = st_reg.save_sp_reg;
  assign NVM_SAVE_STEP_BOOT = st_reg.save_sb_reg;
  assign TARGET_CODE = st_reg.active_reg;
  assign TARGET_MV = st_reg.mv_reg;
  assign CTRL_ACTIVE = st_reg.ctrl_latched_reg;
endmodule

/* File: verification/vsv_setpoint_checker.sv */
// port assertions for the setpoint block
`timescale 1ns/10ps
module vsv_setpoint_checker (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_ACK,
  input wire logic REG_NACK,
  input wire logic CONV_EN,
  input wire logic NVM_SAVE,
  input wire logic [7:0] TARGET_CODE,
  input wire logic [11:0] TARGET_MV,
  input wire logic [1:0] CTRL_ACTIVE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  wire logic cfg_wr = REG_WR && REG_ADDR == 8'hC2;
  wire logic [3:0] boot = REG_WDATA[7:4];
  wire logic fine = REG_WDATA[1] ^ REG_WDATA[0];
  a_one_answer: assert property ((REG_WR || REG_RD) |=> REG_ACK != REG_NACK) else $error("no single answer");
  a_no_stray: assert property (!(REG_WR || REG_RD) |=> !REG_ACK && !REG_NACK) else $error("stray answer");
  a_fine_boot_nack: assert property (cfg_wr && boot != 4'h0 && boot < 4'hD && !fine |=> REG_NACK)
    else $error("fine boot code accepted");
  a_coarse_boot_nack: assert property (cfg_wr && boot > 4'hC && fine |=> REG_NACK)
    else $error("coarse boot code accepted");
  a_code_ro: assert property (REG_WR && (REG_ADDR == 8'hA7 || REG_ADDR == 8'h31) |=> REG_NACK)
    else $error("code write accepted");
  a_off_zero: assert property (!CONV_EN |=> TARGET_CODE == 8'h00) else $error("target while off");
  a_zero_mv: assert property (TARGET_CODE == 8'h00 |-> TARGET_MV == 12'h000) else $error("code 0 not 0 mv");
  a_first_mv: assert property (TARGET_CODE == 8'h01 |-> TARGET_MV == 12'h0FA || TARGET_MV == 12'h1F4)
    else $error("code 1 wrong mv");
  a_store_save: assert property (REG_WR && REG_ADDR == 8'h15 |=> NVM_SAVE && REG_ACK)
    else $error("store without save");
  a_select_held: assert property (CONV_EN && $past(CONV_EN) && $past(CONV_EN, 2) |-> $stable(CTRL_ACTIVE))
    else $error("select moved while on");
endmodule
bind vsv_setpoint vsv_setpoint_checker chk(.SYS_CLK, .RST, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_ACK,
  .REG_NACK, .CONV_EN, .NVM_SAVE, .TARGET_CODE, .TARGET_MV, .CTRL_ACTIVE);

/* File: verification/vsv_nvm_model.sv */
// non-volatile store on the far side of the setpoint block
`timescale 1ns/10ps
module vsv_nvm_model (
  input wire logic clk,
  input wire logic save,
  input wire logic [7:0] save_sp,
  input wire logic [7:0] save_sb,
  input wire logic reload,
  output logic load = 1'b0,
  output logic [7:0] load_sp,
  output logic [7:0] load_sb
);
  logic [7:0] sp = 8'h00;
  logic [7:0] sb = 8'h00;
  // no reset: contents must survive a device reset
  always @(posedge clk) begin
    if (save) begin
      sp <= save_sp;
      sb <= save_sb;
    end
    load <= reload;
  end
  // lines show the inverse outside a reload so stale data cannot pass
  assign load_sp = load ? sp : ~sp;
  assign load_sb = load ? sb : ~sb;
endmodule

/* File: verification/tb_vsv_setpoint.sv */
// self-checking bench for the setpoint block
`timescale 1ns/10ps
module tb_vsv_setpoint import vsv_pkg::*; ;
  typedef struct {logic nk; logic ck; logic [7:0] d;} vsv_exp_t;
  vsv_exp_t q[$];
  vsv_exp_t e;
  logic SYS_CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, CONV_EN = 1'b0;
  logic SS_DONE = 1'b0, SER_CODE_VALID = 1'b0, nvm_reload = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, SER_CODE = 8'h00;
  logic [7:0] REG_RDATA, SER_READBACK, NVM_LOAD_SETPOINT, NVM_LOAD_STEP_BOOT, NVM_SAVE_SETPOINT;
  logic [7:0] NVM_SAVE_STEP_BOOT, TARGET_CODE, v, sb;
  logic [11:0] TARGET_MV;
  logic [1:0] CTRL_ACTIVE;
  logic REG_ACK, REG_NACK, NVM_LOAD, NVM_SAVE, ok;
  int fail_count = 0, num_checks = 0, cycles = 0, seed = 32'hA9C66DB9;
  vsv_setpoint dut(.*);
  vsv_nvm_model nvm(.clk(SYS_CLK), .save(NVM_SAVE), .save_sp(NVM_SAVE_SETPOINT), .save_sb(NVM_SAVE_STEP_BOOT),
    .reload(nvm_reload), .load(NVM_LOAD), .load_sp(NVM_LOAD_SETPOINT), .load_sb(NVM_LOAD_STEP_BOOT));
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: code got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_mv(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: millivolts got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until the next falling edge; idle releases it
  task automatic req(input int w, input logic [7:0] a, input logic [7:0] d, input int nk, input int ck,
    input logic [7:0] x);
    q.push_back('{nk[0], ck[0], x});
    REG_WR = w[0];
    REG_RD = !w[0];
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge SYS_CLK);
  endtask
  task automatic idle();
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    SER_CODE_VALID = 1'b0;
    @(negedge SYS_CLK);
  endtask
  task automatic test_done();
    chk_bit(q.size() == 0, 1'b1);
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(negedge SYS_CLK) begin
    if (REG_ACK || REG_NACK) begin
      e = q.pop_front();
      chk_bit(REG_NACK, e.nk);
      if (e.ck) chk_byte(REG_RDATA, e.d);
    end
  end
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    repeat (3) @(negedge SYS_CLK);
    RST = 1'b0;
    req(0, 8'hA6, 8'h00, 0, 1, 8'h00);
    req(0, 8'hA7, 8'h00, 0, 1, 8'h00);
    req(0, 8'h31, 8'h00, 0, 1, 8'h00);
    req(1, 8'hA7, 8'h12, 1, 0, 8'h00);
    req(1, 8'h31, 8'h12, 1, 0, 8'h00);
    req(0, 8'h55, 8'h00, 1, 1, 8'h00);
    for (int i = 0; i < 64; i++) begin
      v = {i[5:2], 2'($random(seed)), i[1:0]};
      ok = i[5:2] == 4'h0 || (i[5:2] < 4'hD) == (i[1] ^ i[0]);
      if (ok) sb = v;
      req(1, 8'hC2, v, int'(!ok), 0, 8'h00);
    end
    req(0, 8'hC2, 8'h00, 0, 1, sb);
    v = 8'($random(seed) & 32'h7F) + 8'h01;
    req(1, 8'hA0, 8'h02, 0, 0, 8'h00);
    req(1, 8'hC2, 8'hF3, 0, 0, 8'h00);
    req(1, 8'hA6, v, 0, 0, 8'h00);
    idle();
    CONV_EN = 1'b1;
    repeat (2) @(negedge SYS_CLK);
    chk_byte(TARGET_CODE, v);
    chk_mv(TARGET_MV, VSV_BASE_MV_10 + VSV_STEP_MV_10 * v);
    chk_byte(SER_READBACK, v);
    SS_DONE = 1'b1;
    v = v + 8'h10;
    req(1, 8'hA6, v, 0, 0, 8'h00);
    req(1, 8'hA8, 8'h03, 0, 0, 8'h00);
    // a serial code during the select write must be ignored in i2c mode
    SER_CODE = 8'h33;
    SER_CODE_VALID = 1'b1;
    req(1, 8'hA0, 8'h00, 0, 0, 8'h00);
    idle();
    @(negedge SYS_CLK);
    chk_byte(TARGET_CODE, v + 8'h03);
    chk_byte({6'h00, CTRL_ACTIVE}, 8'h02);
    req(1, 8'h15, 8'h00, 0, 0, 8'h00);
    idle();
    chk_byte(NVM_SAVE_SETPOINT, v);
    chk_byte(NVM_SAVE_STEP_BOOT, 8'hF3);
    CONV_EN = 1'b0;
    SS_DONE = 1'b0;
    @(negedge SYS_CLK);
    RST = 1'b1;
    @(negedge SYS_CLK);
    RST = 1'b0;
    nvm_reload = 1'b1;
    @(negedge SYS_CLK);
    nvm_reload = 1'b0;
    @(negedge SYS_CLK);
    req(0, 8'hA6, 8'h00, 0, 1, v);
    req(0, 8'hC2, 8'h00, 0, 1, 8'hF3);
    req(1, 8'hA8, 8'h01, 1, 0, 8'h00);
    req(1, 8'hA0, 8'h03, 0, 0, 8'h00);
    req(1, 8'hC2, 8'h11, 0, 0, 8'h00);
    req(1, 8'hA6, 8'h01, 0, 0, 8'h00);
    idle();
    CONV_EN = 1'b1;
    repeat (2) @(negedge SYS_CLK);
    chk_mv(TARGET_MV, VSV_BASE_MV_5 + VSV_STEP_MV_5);
    // shared mode: boot code plus offset at start, serial code plus start offset later
    CONV_EN = 1'b0;
    req(1, 8'hA0, 8'h01, 0, 0, 8'h00);
    req(1, 8'hA8, 8'h02, 0, 0, 8'h00);
    idle();
    CONV_EN = 1'b1;
    repeat (2) @(negedge SYS_CLK);
    chk_byte(TARGET_CODE, 8'h67);
    SS_DONE = 1'b1;
    SER_CODE = 8'h40;
    SER_CODE_VALID = 1'b1;
    req(1, 8'hA8, 8'h05, 0, 0, 8'h00);
    idle();
    chk_byte(TARGET_CODE, 8'h42);
    chk_mv(TARGET_MV, VSV_BASE_MV_5 + VSV_STEP_MV_5 * 8'h42);
    // serial-only mode: boot code at start, raw serial code later, setpoint writes ignored
    CONV_EN = 1'b0;
    req(1, 8'hA0, 8'h00, 0, 0, 8'h00);
    req(1, 8'hC2, 8'hD0, 0, 0, 8'h00);
    idle();
    CONV_EN = 1'b1;
    repeat (2) @(negedge SYS_CLK);
    chk_byte(TARGET_CODE, 8'h6F);
    chk_mv(TARGET_MV, VSV_BASE_MV_10 + VSV_STEP_MV_10 * 8'h6F);
    SER_CODE = 8'h20;
    SER_CODE_VALID = 1'b1;
    req(1, 8'hA6, 8'h77, 0, 0, 8'h00);
    idle();
    chk_byte(TARGET_CODE, 8'h20);
    req(0, 8'hA6, 8'h00, 0, 1, 8'h01);
    idle();
    test_done();
  end
endmodule
